// ### smm_pkg.sv
package smm_pkg;

    // ------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------
    localparam logic [15:0] SMM_STATUS_ADDR   = 16'h2200;
    localparam logic [15:0] SMM_FSRC_ADDR     = 16'h2201;
    localparam logic [15:0] SMM_RSRC_ADDR     = 16'h2202;
    localparam logic [15:0] SMM_BASE_ADDR     = 16'h2203;
    localparam logic [15:0] SMM_MAXF_ADDR     = 16'h2204;
    localparam logic [15:0] SMM_MSH_ADDR      = 16'h2216;
    localparam logic [15:0] SMM_MSL_ADDR      = 16'h2217;
    localparam logic [15:0] SMM_BOOST_ADDR    = 16'h223b;
    localparam logic [15:0] SMM_MBV_ADDR      = 16'h223c;
    localparam logic [15:0] SMM_MBF_ADDR      = 16'h223d;
    localparam logic [15:0] SMM_VFC_ADDR      = 16'h223e;
    localparam logic [15:0] SMM_VFG_ADDR      = 16'h223f;
    localparam logic [15:0] SMM_VCG_ADDR      = 16'h2240;
    localparam logic [15:0] SMM_SCG_ADDR      = 16'h2241;
    localparam logic [15:0] SMM_ULH_ADDR      = 16'h224f;
    localparam logic [15:0] SMM_ULL_ADDR      = 16'h2250;
    localparam logic [15:0] SMM_LLH_ADDR      = 16'h2251;
    localparam logic [15:0] SMM_LLL_ADDR      = 16'h2252;
    localparam logic [15:0] SMM_RMODE_ADDR    = 16'h2269;
    localparam logic [15:0] SMM_RVOLT_ADDR    = 16'h226a;

    // ------------------------------------------------------------
    // Ranges and encodings
    // ------------------------------------------------------------
    localparam logic [15:0] SMM_RSRC_MIN      = 16'h0001;
    localparam logic [15:0] SMM_RSRC_MAX      = 16'h0004;
    localparam logic [15:0] SMM_FREQ_MIN      = 16'h012c;
    localparam logic [15:0] SMM_MAXF_MAX      = 16'h0fa0;
    localparam logic [31:0] SMM_DECI_TO_CENTI = 32'h0000000a;
    localparam logic [15:0] SMM_BOOST_MAX     = 16'h0001;
    localparam logic [15:0] SMM_MBV_MIN       = 16'h0014;
    localparam logic [15:0] SMM_MBV_MAX       = 16'h00c8;
    localparam logic [15:0] SMM_BYTE_MAX      = 16'h00ff;
    localparam logic [15:0] SMM_VFC_MAX       = 16'h0003;
    localparam logic [15:0] SMM_VFG_MIN       = 16'h0014;
    localparam logic [15:0] SMM_VFG_MAX       = 16'h0064;
    localparam logic [15:0] SMM_RMODE_MAX     = 16'h0002;
    localparam logic [15:0] SMM_LOWV_MAX      = 16'h0004;
    localparam logic [15:0] SMM_HIGHV_MIN     = 16'h0005;
    localparam logic [15:0] SMM_HIGHV_MAX     = 16'h000a;

    // ------------------------------------------------------------
    // Reset values and status bits
    // ------------------------------------------------------------
    localparam logic [15:0] SMM_FSRC_RST      = 16'h0001;
    localparam logic [15:0] SMM_RSRC_RST      = 16'h0001;
    localparam logic [15:0] SMM_FREQ_RST      = 16'h0258;
    localparam logic [15:0] SMM_MBV_RST       = 16'h0014;
    localparam logic [15:0] SMM_VFG_RST       = 16'h0064;
    localparam int          SMM_ST_REJ_BIT    = 0;
    localparam int          SMM_ST_UNM_BIT    = 1;
    localparam int          SMM_ST_HV_BIT     = 2;

    typedef enum logic [15:0] {
        SMM_SRC_KNOB     = 16'h0000,
        SMM_SRC_TERMINAL = 16'h0001,
        SMM_SRC_PANEL    = 16'h0002,
        SMM_SRC_SERIAL   = 16'h0003,
        SMM_SRC_OPTION   = 16'h0004,
        SMM_SRC_PULSE    = 16'h0006,
        SMM_SRC_SEQUENCE = 16'h0007,
        SMM_SRC_COMPUTED = 16'h000a
    } smm_freq_src_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wrData;
        logic        wr;
        logic        rd;
    } smm_bus_req_type;

    typedef struct packed {
        logic [15:0] freqSourceCode;
        logic [15:0] runSourceCode;
        logic [15:0] baseFreq;
        logic [15:0] maxFreq;
        logic [31:0] multispeedFrequency;
        logic [15:0] boostMethodCode;
        logic [15:0] boostValue;
        logic [15:0] boostFreq;
        logic [15:0] vfCurveCode;
        logic [15:0] vfGain;
        logic [15:0] voltCompGain;
        logic [15:0] slipCompGain;
        logic [31:0] upperFrequencyLimit;
        logic [31:0] lowerFrequencyLimit;
        logic [15:0] regulationModeCode;
        logic [15:0] regulationVoltageCode;
    } smm_settings_type;

endpackage

// ### smm_regs.sv
`timescale 1ns/1ps
module smm_regs (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire smm_pkg::smm_bus_req_type  busReq,
    input  wire logic [31:0]               startFreq,
    input  wire logic                      highVoltUnit,
    output logic [15:0]                    rdData,
    output smm_pkg::smm_settings_type      settings,
    output logic                           writeRejected,
    output logic                           accessUnmapped
);
    import smm_pkg::*;

    smm_settings_type cfg_reg;
    logic [15:0]      msStage_reg;
    logic [15:0]      ulStage_reg;
    logic [15:0]      llStage_reg;
    logic [15:0]      rdData_reg;
    logic [15:0]      rdData_next;
    logic [2:0]       status_reg;
    logic             hvMeta_reg;
    logic             hvSync_reg;
    logic             rej_reg;
    logic             unm_reg;
    logic             mapped;
    logic             legal;
    logic [15:0]      d;
    logic [31:0]      maxCenti;
    logic [31:0]      msNew;
    logic [31:0]      ulNew;
    logic [31:0]      llNew;
    logic             wrOk;
    logic             wrBad;

    assign d        = busReq.wrData;
    assign maxCenti = 32'({16'h0000, cfg_reg.maxFreq} * SMM_DECI_TO_CENTI);
    assign msNew    = {msStage_reg, d};
    assign ulNew    = {ulStage_reg, d};
    assign llNew    = {llStage_reg, d};
    assign wrOk     = busReq.wr && mapped && legal;
    assign wrBad    = busReq.wr && mapped && !legal;

    assign rdData         = rdData_reg;
    assign settings       = cfg_reg;
    assign writeRejected  = rej_reg;
    assign accessUnmapped = unm_reg;

    function automatic logic srcOk(input logic [15:0] v);
        case (v)
            SMM_SRC_KNOB, SMM_SRC_TERMINAL, SMM_SRC_PANEL,
            SMM_SRC_SERIAL, SMM_SRC_OPTION, SMM_SRC_PULSE,
            SMM_SRC_SEQUENCE, SMM_SRC_COMPUTED: srcOk = 1'b1;
            default: srcOk = 1'b0;
        endcase
    endfunction

    function automatic logic zeroOrIn(input logic [31:0] v,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        zeroOrIn = (v == 32'h00000000) || (v >= lo && v <= hi);
    endfunction

    // ------------------------------------------------------------
    // Voltage class strap synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hvMeta_reg <= 1'b0;
            hvSync_reg <= 1'b0;
        end else begin
            hvMeta_reg <= highVoltUnit;
            hvSync_reg <= hvMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // Write decode and legality check
    // ------------------------------------------------------------
    // A 32-bit value can only be judged once both halves are known,
    // so the high word is staged and the low word write commits.
    always_comb begin
        mapped = 1'b1;
        legal  = 1'b0;
        if (busReq.addr == SMM_STATUS_ADDR) begin
            legal = 1'b1;
        end else if (busReq.addr == SMM_FSRC_ADDR) begin
            legal = srcOk(d);
        end else if (busReq.addr == SMM_RSRC_ADDR) begin
            legal = d >= SMM_RSRC_MIN && d <= SMM_RSRC_MAX;
        end else if (busReq.addr == SMM_BASE_ADDR) begin
            legal = d >= SMM_FREQ_MIN && d <= cfg_reg.maxFreq;
        end else if (busReq.addr == SMM_MAXF_ADDR) begin
            legal = d >= SMM_FREQ_MIN && d <= SMM_MAXF_MAX;
        end else if (busReq.addr == SMM_MSH_ADDR) begin
            legal = 1'b1;
        end else if (busReq.addr == SMM_MSL_ADDR) begin
            legal = zeroOrIn(msNew, startFreq, maxCenti);
        end else if (busReq.addr == SMM_BOOST_ADDR) begin
            legal = d <= SMM_BOOST_MAX;
        end else if (busReq.addr == SMM_MBV_ADDR) begin
            legal = d >= SMM_MBV_MIN && d <= SMM_MBV_MAX;
        end else if (busReq.addr == SMM_MBF_ADDR) begin
            legal = d <= SMM_BYTE_MAX;
        end else if (busReq.addr == SMM_VFC_ADDR) begin
            legal = d <= SMM_VFC_MAX;
        end else if (busReq.addr == SMM_VFG_ADDR) begin
            legal = d >= SMM_VFG_MIN && d <= SMM_VFG_MAX;
        end else if (busReq.addr == SMM_VCG_ADDR ||
                     busReq.addr == SMM_SCG_ADDR) begin
            legal = d <= SMM_BYTE_MAX;
        end else if (busReq.addr == SMM_ULH_ADDR ||
                     busReq.addr == SMM_LLH_ADDR) begin
            legal = 1'b1;
        end else if (busReq.addr == SMM_ULL_ADDR) begin
            legal = zeroOrIn(ulNew, cfg_reg.lowerFrequencyLimit,
                             maxCenti);
        end else if (busReq.addr == SMM_LLL_ADDR) begin
            legal = zeroOrIn(llNew, startFreq, maxCenti);
        end else if (busReq.addr == SMM_RMODE_ADDR) begin
            legal = d <= SMM_RMODE_MAX;
        end else if (busReq.addr == SMM_RVOLT_ADDR) begin
            legal = hvSync_reg ? (d >= SMM_HIGHV_MIN &&
                                  d <= SMM_HIGHV_MAX)
                               : (d <= SMM_LOWV_MAX);
        end else begin
            mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Stored settings
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_reg <= '0;
            cfg_reg.freqSourceCode <= SMM_FSRC_RST;
            cfg_reg.runSourceCode  <= SMM_RSRC_RST;
            cfg_reg.baseFreq       <= SMM_FREQ_RST;
            cfg_reg.maxFreq        <= SMM_FREQ_RST;
            cfg_reg.boostValue     <= SMM_MBV_RST;
            cfg_reg.vfGain         <= SMM_VFG_RST;
        end else if (wrOk) begin
            if (busReq.addr == SMM_FSRC_ADDR) begin
                cfg_reg.freqSourceCode <= d;
            end else if (busReq.addr == SMM_RSRC_ADDR) begin
                cfg_reg.runSourceCode <= d;
            end else if (busReq.addr == SMM_BASE_ADDR) begin
                cfg_reg.baseFreq <= d;
            end else if (busReq.addr == SMM_MAXF_ADDR) begin
                cfg_reg.maxFreq <= d;
            end else if (busReq.addr == SMM_MSL_ADDR) begin
                cfg_reg.multispeedFrequency <= msNew;
            end else if (busReq.addr == SMM_BOOST_ADDR) begin
                cfg_reg.boostMethodCode <= d;
            end else if (busReq.addr == SMM_MBV_ADDR) begin
                cfg_reg.boostValue <= d;
            end else if (busReq.addr == SMM_MBF_ADDR) begin
                cfg_reg.boostFreq <= d;
            end else if (busReq.addr == SMM_VFC_ADDR) begin
                cfg_reg.vfCurveCode <= d;
            end else if (busReq.addr == SMM_VFG_ADDR) begin
                cfg_reg.vfGain <= d;
            end else if (busReq.addr == SMM_VCG_ADDR) begin
                cfg_reg.voltCompGain <= d;
            end else if (busReq.addr == SMM_SCG_ADDR) begin
                cfg_reg.slipCompGain <= d;
            end else if (busReq.addr == SMM_ULL_ADDR) begin
                cfg_reg.upperFrequencyLimit <= ulNew;
            end else if (busReq.addr == SMM_LLL_ADDR) begin
                cfg_reg.lowerFrequencyLimit <= llNew;
            end else if (busReq.addr == SMM_RMODE_ADDR) begin
                cfg_reg.regulationModeCode <= d;
            end else if (busReq.addr == SMM_RVOLT_ADDR) begin
                cfg_reg.regulationVoltageCode <= d;
            end
        end
    end

    // ------------------------------------------------------------
    // High-word staging
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            msStage_reg <= 16'h0000;
            ulStage_reg <= 16'h0000;
            llStage_reg <= 16'h0000;
        end else if (busReq.wr) begin
            if (busReq.addr == SMM_MSH_ADDR) begin
                msStage_reg <= d;
            end else if (busReq.addr == SMM_ULH_ADDR) begin
                ulStage_reg <= d;
            end else if (busReq.addr == SMM_LLH_ADDR) begin
                llStage_reg <= d;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and access error pulses
    // ------------------------------------------------------------
    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_reg <= 3'h0;
            rej_reg    <= 1'b0;
            unm_reg    <= 1'b0;
        end else begin
            rej_reg <= wrBad;
            unm_reg <= (busReq.wr || busReq.rd) && !mapped;
            if (busReq.wr && busReq.addr == SMM_STATUS_ADDR) begin
                status_reg[1:0] <= status_reg[1:0] & ~d[1:0];
            end
            if (wrBad) begin
                status_reg[SMM_ST_REJ_BIT] <= 1'b1;
            end
            if ((busReq.wr || busReq.rd) && !mapped) begin
                status_reg[SMM_ST_UNM_BIT] <= 1'b1;
            end
            status_reg[SMM_ST_HV_BIT] <= hvSync_reg;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // High words read back the committed value, not the staged one.
    always_comb begin
        rdData_next = 16'h0000;
        if (!busReq.rd) begin
            rdData_next = 16'h0000;
        end else if (busReq.addr == SMM_STATUS_ADDR) begin
            rdData_next = {13'h0000, status_reg};
        end else if (busReq.addr == SMM_FSRC_ADDR) begin
            rdData_next = cfg_reg.freqSourceCode;
        end else if (busReq.addr == SMM_RSRC_ADDR) begin
            rdData_next = cfg_reg.runSourceCode;
        end else if (busReq.addr == SMM_BASE_ADDR) begin
            rdData_next = cfg_reg.baseFreq;
        end else if (busReq.addr == SMM_MAXF_ADDR) begin
            rdData_next = cfg_reg.maxFreq;
        end else if (busReq.addr == SMM_MSH_ADDR) begin
            rdData_next = cfg_reg.multispeedFrequency[31:16];
        end else if (busReq.addr == SMM_MSL_ADDR) begin
            rdData_next = cfg_reg.multispeedFrequency[15:0];
        end else if (busReq.addr == SMM_BOOST_ADDR) begin
            rdData_next = cfg_reg.boostMethodCode;
        end else if (busReq.addr == SMM_MBV_ADDR) begin
            rdData_next = cfg_reg.boostValue;
        end else if (busReq.addr == SMM_MBF_ADDR) begin
            rdData_next = cfg_reg.boostFreq;
        end else if (busReq.addr == SMM_VFC_ADDR) begin
            rdData_next = cfg_reg.vfCurveCode;
        end else if (busReq.addr == SMM_VFG_ADDR) begin
            rdData_next = cfg_reg.vfGain;
        end else if (busReq.addr == SMM_VCG_ADDR) begin
            rdData_next = cfg_reg.voltCompGain;
        end else if (busReq.addr == SMM_SCG_ADDR) begin
            rdData_next = cfg_reg.slipCompGain;
        end else if (busReq.addr == SMM_ULH_ADDR) begin
            rdData_next = cfg_reg.upperFrequencyLimit[31:16];
        end else if (busReq.addr == SMM_ULL_ADDR) begin
            rdData_next = cfg_reg.upperFrequencyLimit[15:0];
        end else if (busReq.addr == SMM_LLH_ADDR) begin
            rdData_next = cfg_reg.lowerFrequencyLimit[31:16];
        end else if (busReq.addr == SMM_LLL_ADDR) begin
            rdData_next = cfg_reg.lowerFrequencyLimit[15:0];
        end else if (busReq.addr == SMM_RMODE_ADDR) begin
            rdData_next = cfg_reg.regulationModeCode;
        end else if (busReq.addr == SMM_RVOLT_ADDR) begin
            rdData_next = cfg_reg.regulationVoltageCode;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData_reg <= 16'h0000;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    freq_src_a: assert property (srcOk(cfg_reg.freqSourceCode))
        else $error("frequency source code illegal");
    run_src_a: assert property (cfg_reg.runSourceCode >= SMM_RSRC_MIN &&
        cfg_reg.runSourceCode <= SMM_RSRC_MAX)
        else $error("run source code illegal");
    max_freq_a: assert property (cfg_reg.maxFreq >= SMM_FREQ_MIN &&
        cfg_reg.maxFreq <= SMM_MAXF_MAX)
        else $error("maximum frequency out of range");
    base_commit_a: assert property (wrOk && busReq.addr == SMM_BASE_ADDR
        |=> cfg_reg.baseFreq == $past(d) &&
            cfg_reg.baseFreq <= cfg_reg.maxFreq)
        else $error("base frequency commit wrong");
    ms_commit_a: assert property (wrOk && busReq.addr == SMM_MSL_ADDR
        |=> cfg_reg.multispeedFrequency == $past(msNew))
        else $error("multispeed commit wrong");
    boost_code_a: assert property (cfg_reg.boostMethodCode <=
        SMM_BOOST_MAX)
        else $error("boost method code illegal");
    boost_val_a: assert property (cfg_reg.boostValue >= SMM_MBV_MIN &&
        cfg_reg.boostValue <= SMM_MBV_MAX &&
        cfg_reg.boostFreq <= SMM_BYTE_MAX)
        else $error("manual boost setting out of range");
    vf_curve_a: assert property (cfg_reg.vfCurveCode <= SMM_VFC_MAX &&
        cfg_reg.vfGain >= SMM_VFG_MIN &&
        cfg_reg.vfGain <= SMM_VFG_MAX)
        else $error("curve setting out of range");
    comp_gain_a: assert property (cfg_reg.voltCompGain <= SMM_BYTE_MAX &&
        cfg_reg.slipCompGain <= SMM_BYTE_MAX)
        else $error("compensation gain out of range");
    upper_limit_a: assert property (wrOk && busReq.addr == SMM_ULL_ADDR
        |=> cfg_reg.upperFrequencyLimit == $past(ulNew))
        else $error("upper limit commit wrong");
    lower_limit_a: assert property (wrOk && busReq.addr == SMM_LLL_ADDR
        |=> cfg_reg.lowerFrequencyLimit == $past(llNew))
        else $error("lower limit commit wrong");
    reg_mode_a: assert property (cfg_reg.regulationModeCode <=
        SMM_RMODE_MAX)
        else $error("regulation mode illegal");
    volt_class_a: assert property (wrOk && busReq.addr == SMM_RVOLT_ADDR
        && hvSync_reg |=> cfg_reg.regulationVoltageCode >=
        SMM_HIGHV_MIN)
        else $error("low-class voltage taken on high unit");
    gap_ignore_a: assert property ((busReq.wr || busReq.rd) && !mapped
        |=> $stable(cfg_reg) && accessUnmapped && rdData == 16'h0000
        ##1 !accessUnmapped || $past(!mapped))
        else $error("gap access had an effect");
    reject_keep_a: assert property (wrBad |=> $stable(cfg_reg) &&
        writeRejected && status_reg[SMM_ST_REJ_BIT])
        else $error("rejected write changed a setting");

    ms_write_c: cover property (wrOk && busReq.addr == SMM_MSL_ADDR);
    reject_c: cover property (wrBad);
    gap_c: cover property (busReq.rd && !mapped);
    clear_c: cover property (busReq.wr && busReq.addr == SMM_STATUS_ADDR
        ##1 status_reg[1:0] == 2'h0);

endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import smm_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic             clk_sys      = 1'b0;
    logic             rst          = 1'b1;
    smm_bus_req_type  busReq       = '0;
    logic [31:0]      startFreq    = 32'h00000032;
    logic             highVoltUnit = 1'b0;
    logic [15:0]      rdData;
    smm_settings_type settings;
    logic             writeRejected;
    logic             accessUnmapped;
    int               fails    = 0;
    int               testsRun = 0;
    int               cycles   = 0;
    logic [15:0]      a, lo, hi, expV;
    logic [31:0]      v32, e32, lowB;
    logic             ok;
    logic [31:0] rstTab [6] = '{32'h2201_0001, 32'h2203_0258, 32'h2204_0258,
                                32'h223c_0014, 32'h223f_0064, 32'h226a_0000};
    logic [47:0] rngTab [10] = '{48'h2202_0001_0004, 48'h2204_012c_0fa0,
        48'h223b_0000_0001, 48'h223c_0014_00c8, 48'h223d_0000_00ff,
        48'h223e_0000_0003, 48'h223f_0014_0064, 48'h2240_0000_00ff,
        48'h2241_0000_00ff, 48'h2269_0000_0002};
    logic [31:0] vals [7] = '{32'd0, 32'd49, 32'd50, 32'd10000, 32'd10001,
                              32'h00011388, 32'd5000};
    logic [15:0] wide [3] = '{16'h2216, 16'h2251, 16'h224f};
    logic [15:0] gaps [8] = '{16'h2205, 16'h2215, 16'h2218, 16'h223a,
                              16'h2242, 16'h224e, 16'h2253, 16'h226b};

    always #2 clk_sys = ~clk_sys;

    smm_regs dut (.clk_sys(clk_sys), .rst(rst), .busReq(busReq),
        .startFreq(startFreq), .highVoltUnit(highVoltUnit), .rdData(rdData),
        .settings(settings), .writeRejected(writeRejected),
        .accessUnmapped(accessUnmapped));

    // ------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkFlag(input logic got, input logic exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobes drop after one cycle; the answer is sampled 1 ns later.
    task automatic xfer(input logic w, input logic [15:0] ad, dt);
        @(posedge clk_sys);
        busReq <= '{addr: ad, wrData: dt, wr: w, rd: ~w};
        @(posedge clk_sys);
        busReq.wr <= 1'b0;
        busReq.rd <= 1'b0;
        #1;
    endtask
    task automatic wrChk(input logic [15:0] ad, dt, input logic rej);
        xfer(1'b1, ad, dt);
        chkFlag(writeRejected, rej);
    endtask
    task automatic rdChk(input logic [15:0] ad, exp);
        xfer(1'b0, ad, 16'h0000);
        chk({16'h0000, rdData}, {16'h0000, exp});
    endtask
    task automatic testDone();
        $display("Checks run %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            testDone();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rstTab[i]) rdChk(rstTab[i][31:16], rstTab[i][15:0]);
        $display("reset values done");
        for (int i = 0; i < 12; i++) begin
            ok = i <= 4 || i == 6 || i == 7 || i == 10;
            if (ok) expV = i[15:0];
            wrChk(16'h2201, i[15:0], !ok);
            rdChk(16'h2201, expV);
        end
        // Below zero wraps to ffff, which none of these registers accepts.
        foreach (rngTab[i]) begin
            {a, lo, hi} = rngTab[i];
            wrChk(a, lo - 16'h0001, 1'b1);
            wrChk(a, lo, 1'b0);
            rdChk(a, lo);
            wrChk(a, hi + 16'h0001, 1'b1);
            wrChk(a, hi, 1'b0);
            rdChk(a, hi);
        end
        $display("range tests done");
        wrChk(16'h2204, 16'h03e8, 1'b0);
        wrChk(16'h2203, 16'h03e9, 1'b1);
        wrChk(16'h2203, 16'h03e8, 1'b0);
        wrChk(16'h2203, 16'h012b, 1'b1);
        rdChk(16'h2203, 16'h03e8);
        for (int hv = 0; hv < 2; hv++) begin
            @(posedge clk_sys) highVoltUnit <= hv[0];
            repeat (3) @(posedge clk_sys);
            for (int i = 0; i < 12; i++) begin
                ok = hv == 1 ? (i >= 5 && i <= 10) : i <= 4;
                wrChk(16'h226a, i[15:0], !ok);
            end
        end
        rdChk(16'h226a, 16'h000a);
        $display("base and voltage tests done");
        // Maximum is 1000 in 0.1 Hz, so the ceiling is 10000 in 0.01 Hz.
        for (int k = 0; k < 3; k++) begin
            lowB = k < 2 ? startFreq : 32'd5000;
            foreach (vals[j]) begin
                v32 = vals[j];
                ok = v32 == 0 || (v32 >= lowB && v32 <= 32'd10000);
                if (ok) e32 = v32;
                wrChk(wide[k], v32[31:16], 1'b0);
                wrChk(wide[k] + 16'h0001, v32[15:0], !ok);
                rdChk(wide[k], e32[31:16]);
                rdChk(wide[k] + 16'h0001, e32[15:0]);
            end
        end
        chk(settings.multispeedFrequency, 32'd5000);
        $display("wide value tests done");
        foreach (gaps[i]) begin
            xfer(1'b1, gaps[i], 16'hffff);
            chkFlag(accessUnmapped, 1'b1);
            xfer(1'b0, gaps[i], 16'h0000);
            chkFlag(accessUnmapped, 1'b1);
            chk({16'h0000, rdData}, 32'h00000000);
        end
        chk({16'h0000, settings.maxFreq}, 32'h000003e8);
        chk(settings.lowerFrequencyLimit, 32'd5000);
        $display("unmapped tests done");
        // Both sticky bits are set by now and the strap reads high.
        rdChk(16'h2200, 16'h0007);
        wrChk(16'h2200, 16'h0003, 1'b0);
        rdChk(16'h2200, 16'h0004);
        @(posedge clk_sys) rst <= 1'b1;
        @(posedge clk_sys) rst <= 1'b0;
        foreach (rstTab[i]) rdChk(rstTab[i][31:16], rstTab[i][15:0]);
        $display("status and second reset done");
        testDone();
    end
endmodule
